// *** logic/lbst_pkg.sv ***
/*
 * Shared constants for the local bus strobe timing block: register
 * offsets, field positions, reset values and cycle counts.
 * Assumes a single PCI clock domain at 20 MHz in this build.
 */
package lbst_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0]  LBST_OFS_TIMING_A   = 8'h08;
    localparam logic [7:0]  LBST_OFS_TIMING_B   = 8'h0C;

    // ---------------------------------------------------------------
    // timing_a fields
    // ---------------------------------------------------------------
    localparam int          LBST_A_WR_ASRT_LSB  = 24;
    localparam int          LBST_A_WR_DASRT_LSB = 28;
    localparam logic [31:0] LBST_A_RESET        = 32'h20303030;
    localparam logic [31:0] LBST_A_RESET_PAR    = 32'h21202020;

    // ---------------------------------------------------------------
    // timing_b fields
    // ---------------------------------------------------------------
    localparam int          LBST_B_WD_ASRT_LSB  = 0;
    localparam int          LBST_B_WD_REL_LSB   = 4;
    localparam int          LBST_B_RD_DRV_LSB   = 8;
    localparam int          LBST_B_RD_FLT_LSB   = 12;
    localparam int          LBST_B_BLK_LSB      = 20;
    localparam int          LBST_B_CSDEC_LSB    = 23;
    localparam int          LBST_B_LRST_BIT     = 29;
    localparam int          LBST_B_CLKEN_BIT    = 30;
    localparam int          LBST_B_DSMODE_BIT   = 31;
    localparam logic [31:0] LBST_B_WR_MASK      = 32'hE780FFFF;
    localparam logic [31:0] LBST_B_RESET        = 32'h00C004F0;
    localparam logic [31:0] LBST_B_RESET_PAR    = 32'h012002F0;
    localparam logic [2:0]  LBST_BLK_SIZE       = 3'h4;
    localparam logic [2:0]  LBST_BLK_SIZE_PAR   = 3'h2;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam logic [3:0]  LBST_NIB_MAX        = 4'hA;
    localparam logic [3:0]  LBST_NIB_FLOAT      = 4'hF;
    localparam logic [3:0]  LBST_CNT_LAST       = 4'hB;
    localparam logic [3:0]  LBST_CSDEC_MAX      = 4'h7;
    localparam logic [1:0]  LBST_MODE_FORCE_SEP = 2'h1;
    localparam int          LBST_MEM_CS_LSB     = 10;
    localparam int          LBST_IO_CS_BASE     = 2;

endpackage

// *** logic/lbst_ref_counter.sv ***
/*
 * Reference-cycle counter: zero in the reference cycle, then counts
 * up to the last event slot and stops. Exposes both the present and
 * the next count so that outputs can change in the matching cycle.
 */
`timescale 1ns/1ps
module lbst_ref_counter
    import lbst_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       start_in,
    output logic [3:0]      cnt_out,
    output logic [3:0]      next_cnt_out,
    output logic            active_out,
    output logic            next_active_out
);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_active_out = start_in || (active_out && (cnt_out != LBST_CNT_LAST));
        if (start_in) begin
            next_cnt_out = 4'h0;
        end else if (active_out && (cnt_out != LBST_CNT_LAST)) begin
            next_cnt_out = cnt_out + 4'h1;
        end else begin
            next_cnt_out = cnt_out;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_out    <= 4'h0;
            active_out <= 1'b0;
        end else begin
            cnt_out    <= next_cnt_out;
            active_out <= next_active_out;
        end
    end

endmodule

// *** logic/lbst_top.sv ***
/*
 * Local bus strobe timing: timing registers, reference-cycle tracking,
 * write strobes, data pin drive windows, chip-select decode, local
 * reset and clock output.
 * Assumes FRAME_N_IN and IRDY_N_IN are sampled on CLK_IN by the PCI
 * core; strap and EEPROM-load inputs arrive from outside the domain.
 */
`timescale 1ns/1ps

// Functional notes
// - separate mode, write strobe goes low at timing_a[27:24]; reset 0, parallel 1.
// - data-strobe mode, same field lowers all four data strobes on writes.
// - timing_a[31:28] returns write or data strobes high; reset 2.
// - timing values above 10 are reserved; such accesses are retried.
// - timing_b[3:0] starts data pin drive during writes; reset 0.
// - timing_b[7:4] floats data pins during writes; reset 15.
// - release field at 15 keeps data pins driven outside reads.
// - timing_b[15:12] floats data pins at start of a read; reset 0.
// - timing_b[11:8] drives data pins again at read end; reset 4, parallel 2.
// - release field not 15 ignores read fields, pins float outside writes.
// - timing_b[22:20] is read-only I/O block size code.
// - timing_b[26:23] picks lowest I/O chip-select decode bit A2..A9.
// - memory accesses use fixed 1K decode per chip select.
// - timing_b[29] drives local reset output through a register, one clock later; resets to 0.
// - timing_b[30] enables buffered clock output, else held low.
// - timing_b[31] picks strobe style; forced 0 when mode equals 01.
// - PCI reset also resets local bus logic and peripherals.
// - data pins float while EEPROM configuration loads.
// - reference cycle is two clocks after first IRDY in a frame.
// - address and write data present in reference cycle.
// - data-strobe mode, read-not-write low from reference on writes, high on reads.
module lbst_top
    import lbst_pkg::*;
(
    input  wire logic       CLK_IN,
    input  wire logic       RST_N_IN,
    input  wire logic       FRAME_N_IN,
    input  wire logic       IRDY_N_IN,
    input  wire logic       ACC_WRITE_IN,
    input  wire logic       ACC_MEM_IN,
    input  wire logic [11:0] ACC_ADDR_IN,
    input  wire logic [7:0] ACC_WDATA_IN,
    output logic            ACC_RETRY_OUT,
    output logic            ACC_DONE_OUT,
    output logic [7:0]      ACC_RDATA_OUT,
    input  wire logic       REG_WR_IN,
    input  wire logic       REG_RD_IN,
    input  wire logic [7:0] REG_ADDR_IN,
    input  wire logic [31:0] REG_WDATA_IN,
    output logic [31:0]     REG_RDATA_OUT,
    input  wire logic [1:0] DEV_MODE_IN,
    input  wire logic       PAR_PORT_IN,
    input  wire logic       EE_LOADING_IN,
    output logic [7:0]      LOCAL_ADDRESS_PINS_OUT,
    input  wire logic [7:0] LOCAL_DATA_PINS_IN,
    output logic [7:0]      LOCAL_DATA_PINS_OUT,
    output logic            LOCAL_DATA_PINS_OE_OUT,
    output logic            LOCAL_WRITE_STROBE_N_OUT,
    output logic [3:0]      LOCAL_DATA_STROBES_N_OUT,
    output logic            LOCAL_READ_NOT_WRITE_N_OUT,
    output logic [3:0]      LOCAL_CHIP_SELECTS_N_OUT,
    output logic            LOCAL_RESET_OUT,
    output logic            LOCAL_CLOCK_OUT
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [3:0] nib(input logic [31:0] r, input int lsb);
        nib = r[lsb +: 4];
    endfunction

    function automatic logic hit(input logic act, input logic [3:0] c,
                                 input logic [3:0] f);
        hit = act && (c == f);
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0]  par_sync;
    logic [1:0]  ee_sync;

    always_ff @(posedge CLK_IN) begin
        par_sync <= {par_sync[0], PAR_PORT_IN};
        ee_sync  <= {ee_sync[0], EE_LOADING_IN};
    end

    wire logic   par_mode = par_sync[1];
    wire logic   ee_load  = ee_sync[1];

    // ---------------------------------------------------------------
    // timing registers
    // ---------------------------------------------------------------
    logic [31:0] timing_a;
    logic [31:0] timing_b;
    logic        rst_seen;
    logic        force_sep;

    assign force_sep = (DEV_MODE_IN == LBST_MODE_FORCE_SEP);

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            rst_seen <= 1'b1;
        end else begin
            rst_seen <= 1'b0;
        end
    end

    // reset values load once the strap is through its synchroniser
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || rst_seen) begin
            timing_a <= par_mode ? LBST_A_RESET_PAR : LBST_A_RESET;
        end else if (REG_WR_IN && (REG_ADDR_IN == LBST_OFS_TIMING_A)) begin
            timing_a <= REG_WDATA_IN;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || rst_seen) begin
            timing_b <= par_mode ? LBST_B_RESET_PAR : LBST_B_RESET;
        end else if (REG_WR_IN && (REG_ADDR_IN == LBST_OFS_TIMING_B)) begin
            timing_b <= (REG_WDATA_IN & LBST_B_WR_MASK) | (timing_b & ~LBST_B_WR_MASK);
        end
    end

    wire logic   ds_mode  = timing_b[LBST_B_DSMODE_BIT] && !force_sep;
    wire logic [3:0] wr_asrt  = nib(timing_a, LBST_A_WR_ASRT_LSB);
    wire logic [3:0] wr_dasrt = nib(timing_a, LBST_A_WR_DASRT_LSB);
    wire logic [3:0] wd_asrt  = nib(timing_b, LBST_B_WD_ASRT_LSB);
    wire logic [3:0] wd_rel   = nib(timing_b, LBST_B_WD_REL_LSB);
    wire logic [3:0] rd_drv   = nib(timing_b, LBST_B_RD_DRV_LSB);
    wire logic [3:0] rd_flt   = nib(timing_b, LBST_B_RD_FLT_LSB);
    wire logic [3:0] cs_dec   = nib(timing_b, LBST_B_CSDEC_LSB);
    wire logic   keep_drv = (wd_rel == LBST_NIB_FLOAT);

    // reserved timing values anywhere in the active fields force retry
    wire logic   bad_tim  = (wr_asrt > LBST_NIB_MAX) || (wr_dasrt > LBST_NIB_MAX)
                         || (wd_asrt > LBST_NIB_MAX) || (rd_drv > LBST_NIB_MAX)
                         || (rd_flt > LBST_NIB_MAX)
                         || (!keep_drv && (wd_rel > LBST_NIB_MAX));

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            REG_RDATA_OUT <= 32'h00000000;
        end else if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                LBST_OFS_TIMING_A: REG_RDATA_OUT <= timing_a;
                LBST_OFS_TIMING_B: REG_RDATA_OUT <= {ds_mode, timing_b[30:0]};
                default:           REG_RDATA_OUT <= 32'h00000000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // reference cycle
    // ---------------------------------------------------------------
    logic        irdy_seen;
    logic [1:0]  ref_pipe;
    logic        acc_write;
    logic        acc_mem;
    logic [11:0] acc_addr;
    logic [7:0]  acc_wdata;
    wire logic   in_frame   = !FRAME_N_IN || !IRDY_N_IN;
    wire logic   first_irdy = in_frame && !IRDY_N_IN && !irdy_seen;
    wire logic   ref_cycle  = ref_pipe[1] && !bad_tim;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            irdy_seen <= 1'b0;
        end else if (!in_frame) begin
            irdy_seen <= 1'b0;
        end else if (first_irdy) begin
            irdy_seen <= 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ref_pipe <= 2'h0;
        end else begin
            ref_pipe <= {ref_pipe[0], first_irdy};
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            acc_write <= 1'b0;
            acc_mem   <= 1'b0;
            acc_addr  <= 12'h000;
            acc_wdata <= 8'h00;
        end else if (first_irdy) begin
            acc_write <= ACC_WRITE_IN;
            acc_mem   <= ACC_MEM_IN;
            acc_addr  <= ACC_ADDR_IN;
            acc_wdata <= ACC_WDATA_IN;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ACC_RETRY_OUT <= 1'b0;
        end else begin
            ACC_RETRY_OUT <= ref_pipe[1] && bad_tim;
        end
    end

    // ---------------------------------------------------------------
    // event counter
    // ---------------------------------------------------------------
    logic [3:0]  cnt;
    logic [3:0]  next_cnt;
    logic        active;
    logic        next_active;

    lbst_ref_counter u_cnt (
        .clk_in          (CLK_IN),
        .rst_n_in        (RST_N_IN),
        .start_in        (ref_cycle),
        .cnt_out         (cnt),
        .next_cnt_out    (next_cnt),
        .active_out      (active),
        .next_active_out (next_active)
    );

    wire logic   wr_go = next_active && acc_write;
    wire logic   rd_go = next_active && !acc_write;
    wire logic   ending = active && !next_active;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ACC_DONE_OUT <= 1'b0;
        end else begin
            ACC_DONE_OUT <= ending;
        end
    end

    // ---------------------------------------------------------------
    // strobes
    // ---------------------------------------------------------------
    logic        wr_low;
    logic [3:0]  next_ds;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || !next_active) begin
            wr_low <= 1'b0;
        end else if (hit(wr_go, next_cnt, wr_dasrt)) begin
            wr_low <= 1'b0;
        end else if (hit(wr_go, next_cnt, wr_asrt)) begin
            wr_low <= 1'b1;
        end
    end

    always_comb begin
        next_ds = {4{!(wr_low && ds_mode)}};
    end

    assign LOCAL_WRITE_STROBE_N_OUT = !(wr_low && !ds_mode);
    assign LOCAL_DATA_STROBES_N_OUT = next_ds;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || !next_active) begin
            LOCAL_READ_NOT_WRITE_N_OUT <= 1'b1;
        end else begin
            LOCAL_READ_NOT_WRITE_N_OUT <= !(ds_mode && acc_write);
        end
    end

    // ---------------------------------------------------------------
    // address, chip selects and write data
    // ---------------------------------------------------------------
    logic [1:0]  cs_idx;
    logic [3:0]  dec_bit;

    always_comb begin
        dec_bit = cs_dec + 4'(LBST_IO_CS_BASE);
        if (acc_mem) begin
            cs_idx = acc_addr[LBST_MEM_CS_LSB +: 2];
        end else begin
            cs_idx = acc_addr[dec_bit +: 2];
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            LOCAL_ADDRESS_PINS_OUT   <= 8'h00;
            LOCAL_DATA_PINS_OUT      <= 8'h00;
            LOCAL_CHIP_SELECTS_N_OUT <= 4'hF;
        end else if (ref_cycle) begin
            LOCAL_ADDRESS_PINS_OUT   <= acc_addr[7:0];
            LOCAL_DATA_PINS_OUT      <= acc_write ? acc_wdata : LOCAL_DATA_PINS_OUT;
            LOCAL_CHIP_SELECTS_N_OUT <= ~(4'h1 << cs_idx);
        end else if (!next_active) begin
            LOCAL_CHIP_SELECTS_N_OUT <= 4'hF;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ACC_RDATA_OUT <= 8'h00;
        end else if (hit(rd_go, next_cnt, rd_drv)) begin
            // take the byte on the edge before the pins are driven again
            ACC_RDATA_OUT <= LOCAL_DATA_PINS_IN;
        end
    end

    // ---------------------------------------------------------------
    // data pin drive window
    // ---------------------------------------------------------------
    logic        oe;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || ee_load) begin
            oe <= 1'b0;
        end else if (!next_active) begin
            oe <= keep_drv;
        end else if (acc_write) begin
            if (!keep_drv && hit(wr_go, next_cnt, wd_rel)) begin
                oe <= 1'b0;
            end else if (hit(wr_go, next_cnt, wd_asrt)) begin
                oe <= 1'b1;
            end
        end else if (!keep_drv) begin
            oe <= 1'b0;
        end else if (hit(rd_go, next_cnt, rd_drv)) begin
            oe <= 1'b1;
        end else if (hit(rd_go, next_cnt, rd_flt)) begin
            oe <= 1'b0;
        end
    end

    assign LOCAL_DATA_PINS_OE_OUT = oe;

    // ---------------------------------------------------------------
    // local reset and clock
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            LOCAL_RESET_OUT <= 1'b1;
        end else begin
            LOCAL_RESET_OUT <= timing_b[LBST_B_LRST_BIT];
        end
    end

    assign LOCAL_CLOCK_OUT = CLK_IN && timing_b[LBST_B_CLKEN_BIT];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN || rst_seen);

    sequence s_first_irdy;
        first_irdy && !bad_tim;
    endsequence

    sequence s_ref_start;
        ##3 (active && cnt == 4'h0);
    endsequence

    property p_ref_two;
        s_first_irdy |-> s_ref_start;
    endproperty
    a_ref_two: assert property (p_ref_two) else $error("reference cycle not two clocks");

    property p_retry;
        (ref_pipe[1] && bad_tim) |=> (ACC_RETRY_OUT && !active);
    endproperty
    a_retry: assert property (p_retry) else $error("reserved timing not retried");

    property p_wr_low;
        (active && acc_write && !ds_mode && cnt == wr_asrt && wr_asrt < wr_dasrt)
            |-> !LOCAL_WRITE_STROBE_N_OUT;
    endproperty
    a_wr_low: assert property (p_wr_low) else $error("write strobe not low at field");

    property p_ds_low;
        (active && acc_write && ds_mode && cnt == wr_asrt && wr_asrt < wr_dasrt)
            |-> (LOCAL_DATA_STROBES_N_OUT == 4'h0);
    endproperty
    a_ds_low: assert property (p_ds_low) else $error("data strobes not low at field");

    property p_wr_high;
        (active && cnt == wr_dasrt) |-> (LOCAL_WRITE_STROBE_N_OUT
                                         && LOCAL_DATA_STROBES_N_OUT == 4'hF);
    endproperty
    a_wr_high: assert property (p_wr_high) else $error("strobe not high at field");

    property p_float_idle;
        (!keep_drv && !$past(keep_drv) && !active && !$past(active))
            |-> !LOCAL_DATA_PINS_OE_OUT;
    endproperty
    a_float_idle: assert property (p_float_idle) else $error("pins driven while floating");

    property p_keep_idle;
        (keep_drv && $past(keep_drv) && !ee_load && !$past(ee_load) && !active
            && !$past(active)) |-> LOCAL_DATA_PINS_OE_OUT;
    endproperty
    a_keep_idle: assert property (p_keep_idle) else $error("pins not driven in idle");

    property p_wd_on;
        (active && acc_write && cnt == wd_asrt && !ee_load && !$past(ee_load)
            && (keep_drv || wd_asrt < wd_rel)) |-> LOCAL_DATA_PINS_OE_OUT;
    endproperty
    a_wd_on: assert property (p_wd_on) else $error("write drive not started");

    property p_rd_float;
        (active && !acc_write && cnt == rd_flt && rd_flt != rd_drv) |-> !LOCAL_DATA_PINS_OE_OUT;
    endproperty
    a_rd_float: assert property (p_rd_float) else $error("read float missed");

    property p_ee;
        ee_load |=> !LOCAL_DATA_PINS_OE_OUT;
    endproperty
    a_ee: assert property (p_ee) else $error("pins driven during eeprom load");

    property p_rnw_read;
        (active && !acc_write) |-> LOCAL_READ_NOT_WRITE_N_OUT;
    endproperty
    a_rnw_read: assert property (p_rnw_read) else $error("read-not-write low on read");

    property p_lrst;
        $changed(timing_b[LBST_B_LRST_BIT]) |=> (LOCAL_RESET_OUT == $past(timing_b[LBST_B_LRST_BIT]));
    endproperty
    a_lrst: assert property (p_lrst) else $error("local reset not following bit");

    property p_force_sep;
        force_sep |-> !ds_mode;
    endproperty
    a_force_sep: assert property (p_force_sep) else $error("strobe style not forced");

endmodule

// *** testbench/lbst_periph_model.sv ***
/*
 * Byte-wide peripheral on the local bus: answers reads with a fixed
 * byte and latches written bytes on the write strobe's rising edge.
 * Assumes the bench resolves the data wire from the enable it is given.
 */
`timescale 1ns/1ps
module lbst_periph_model #(
    parameter logic [7:0] RESP = 8'h3C
) (
    input  wire logic [3:0] cs_n_in,
    input  wire logic       wr_n_in,
    input  wire logic       oe_in,
    input  wire logic [7:0] dout_in,
    output logic      [7:0] data_out,
    output logic      [7:0] last_wr_out
);
    // undriven bus rests at the pull-up level
    assign data_out = oe_in ? dout_in : ((cs_n_in != 4'hF) ? RESP : 8'hFF);
    initial last_wr_out = 8'h00;
    always @(posedge wr_n_in) begin
        if (cs_n_in != 4'hF) begin
            last_wr_out <= data_out;
        end
    end
endmodule

// *** testbench/local_bus_strobe_timing_tb.sv ***
/*
 * Self-checking bench for the local bus strobe timing block.
 * Assumes the design's own assertions run alongside; one clock domain.
 */
`timescale 1ns/1ps
module local_bus_strobe_timing_tb;
    import lbst_pkg::*;
    logic        CLK_IN, RST_N_IN, FRAME_N_IN, IRDY_N_IN, ACC_WRITE_IN, ACC_MEM_IN;
    logic [11:0] ACC_ADDR_IN;
    logic [7:0]  ACC_WDATA_IN, ACC_RDATA_OUT, REG_ADDR_IN, LOCAL_ADDRESS_PINS_OUT;
    logic [7:0]  LOCAL_DATA_PINS_IN, LOCAL_DATA_PINS_OUT, lw;
    logic        ACC_RETRY_OUT, ACC_DONE_OUT, REG_WR_IN, REG_RD_IN, PAR_PORT_IN, EE_LOADING_IN;
    logic [31:0] REG_WDATA_IN, REG_RDATA_OUT;
    logic [1:0]  DEV_MODE_IN;
    logic        LOCAL_DATA_PINS_OE_OUT, LOCAL_WRITE_STROBE_N_OUT, LOCAL_READ_NOT_WRITE_N_OUT;
    logic [3:0]  LOCAL_DATA_STROBES_N_OUT, LOCAL_CHIP_SELECTS_N_OUT;
    logic        LOCAL_RESET_OUT, LOCAL_CLOCK_OUT;
    int          miscompares = 0;
    int          compares = 0;
    int          cycles = 0;

    lbst_top lbst_top_inst (.CLK_IN, .RST_N_IN, .FRAME_N_IN, .IRDY_N_IN, .ACC_WRITE_IN,
        .ACC_MEM_IN, .ACC_ADDR_IN, .ACC_WDATA_IN, .ACC_RETRY_OUT, .ACC_DONE_OUT,
        .ACC_RDATA_OUT, .REG_WR_IN, .REG_RD_IN, .REG_ADDR_IN, .REG_WDATA_IN,
        .REG_RDATA_OUT, .DEV_MODE_IN, .PAR_PORT_IN, .EE_LOADING_IN,
        .LOCAL_ADDRESS_PINS_OUT, .LOCAL_DATA_PINS_IN, .LOCAL_DATA_PINS_OUT,
        .LOCAL_DATA_PINS_OE_OUT, .LOCAL_WRITE_STROBE_N_OUT, .LOCAL_DATA_STROBES_N_OUT,
        .LOCAL_READ_NOT_WRITE_N_OUT, .LOCAL_CHIP_SELECTS_N_OUT, .LOCAL_RESET_OUT,
        .LOCAL_CLOCK_OUT);
    lbst_periph_model lbst_periph_model_inst (.cs_n_in(LOCAL_CHIP_SELECTS_N_OUT),
        .wr_n_in(LOCAL_WRITE_STROBE_N_OUT), .oe_in(LOCAL_DATA_PINS_OE_OUT),
        .dout_in(LOCAL_DATA_PINS_OUT), .data_out(LOCAL_DATA_PINS_IN), .last_wr_out(lw));

    // ---------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ---------------------------------------------------------------
    initial begin
        CLK_IN = 1'b0;
        forever #25 CLK_IN = ~CLK_IN;
    end
    task automatic finish_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge CLK_IN) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            finish_test;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK_IN);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge CLK_IN) {REG_WR_IN, REG_ADDR_IN, REG_WDATA_IN} = {1'b1, a, d};
        @(negedge CLK_IN) REG_WR_IN = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge CLK_IN) {REG_RD_IN, REG_ADDR_IN} = {1'b1, a};
        @(negedge CLK_IN) REG_RD_IN = 1'b0;
        cyc(1);
        chk(REG_RDATA_OUT, e);
    endtask
    // leaves the caller in the reference cycle, two edges after first IRDY
    task automatic acc(input logic w, input logic m, input logic [11:0] a,
                       input logic [7:0] d);
        @(negedge CLK_IN) {FRAME_N_IN, IRDY_N_IN, ACC_WRITE_IN, ACC_MEM_IN} = {2'b00, w, m};
        {ACC_ADDR_IN, ACC_WDATA_IN} = {a, d};
        @(negedge CLK_IN) {FRAME_N_IN, IRDY_N_IN} = 2'b11;
        cyc(2);
    endtask
    task automatic wait_done;
        int i;
        for (i = 0; i < 20 && ACC_DONE_OUT !== 1'b1; i++) cyc(1);
        chk(ACC_DONE_OUT, 1'b1);
        cyc(1);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {RST_N_IN, FRAME_N_IN, IRDY_N_IN, ACC_WRITE_IN, ACC_MEM_IN} = 5'b01100;
        {ACC_ADDR_IN, ACC_WDATA_IN, REG_WR_IN, REG_RD_IN, REG_ADDR_IN} = '0;
        {REG_WDATA_IN, DEV_MODE_IN, PAR_PORT_IN, EE_LOADING_IN} = '0;
        cyc(6);
        RST_N_IN = 1'b1;
        cyc(2);
        reg_rd(LBST_OFS_TIMING_A, LBST_A_RESET);
        reg_rd(LBST_OFS_TIMING_B, LBST_B_RESET);
        reg_rd(8'h10, 32'h0);
        chk(LOCAL_DATA_PINS_OE_OUT, 1'b1);
        acc(1'b1, 1'b0, 12'h018, 8'hA5);
        chk({LOCAL_ADDRESS_PINS_OUT, LOCAL_DATA_PINS_OUT}, 16'h18A5);
        chk({LOCAL_DATA_PINS_OE_OUT, LOCAL_WRITE_STROBE_N_OUT}, 2'b10);
        chk(LOCAL_CHIP_SELECTS_N_OUT, 4'h7);
        cyc(2);
        chk(LOCAL_WRITE_STROBE_N_OUT, 1'b1);
        wait_done;
        chk(lw, 8'hA5);
        acc(1'b1, 1'b1, 12'h800, 8'h5A);
        chk(LOCAL_CHIP_SELECTS_N_OUT, 4'hB);
        wait_done;
        acc(1'b0, 1'b0, 12'h008, 8'h00);
        chk(LOCAL_DATA_PINS_OE_OUT, 1'b0);
        cyc(4);
        chk(LOCAL_DATA_PINS_OE_OUT, 1'b1);
        wait_done;
        chk(ACC_RDATA_OUT, 8'h3C);
        reg_wr(LBST_OFS_TIMING_B, 32'h80800030);
        reg_wr(LBST_OFS_TIMING_A, 32'h31303030);
        reg_rd(LBST_OFS_TIMING_B, 32'h80C00030);
        acc(1'b1, 1'b0, 12'h008, 8'h11);
        chk({LOCAL_READ_NOT_WRITE_N_OUT, LOCAL_DATA_STROBES_N_OUT}, 5'h0F);
        cyc(1);
        chk({LOCAL_DATA_STROBES_N_OUT, LOCAL_WRITE_STROBE_N_OUT}, 5'h01);
        cyc(2);
        chk({LOCAL_DATA_STROBES_N_OUT, LOCAL_DATA_PINS_OE_OUT}, 5'h1E);
        wait_done;
        acc(1'b0, 1'b0, 12'h008, 8'h00);
        chk(LOCAL_READ_NOT_WRITE_N_OUT, 1'b1);
        cyc(4);
        chk(LOCAL_DATA_PINS_OE_OUT, 1'b0);
        wait_done;
        DEV_MODE_IN = LBST_MODE_FORCE_SEP;
        reg_rd(LBST_OFS_TIMING_B, 32'h00C00030);
        DEV_MODE_IN = 2'h0;
        reg_wr(LBST_OFS_TIMING_A, 32'h3B303030);
        acc(1'b1, 1'b0, 12'h008, 8'h22);
        chk(ACC_RETRY_OUT, 1'b1);
        cyc(12);
        reg_wr(LBST_OFS_TIMING_A, LBST_A_RESET);
        reg_wr(LBST_OFS_TIMING_B, 32'hFFFFFFFF);
        reg_rd(LBST_OFS_TIMING_B, LBST_B_WR_MASK | (LBST_B_RESET & ~LBST_B_WR_MASK));
        chk(LOCAL_RESET_OUT, 1'b1);
        @(posedge CLK_IN) #1 chk(LOCAL_CLOCK_OUT, 1'b1);
        reg_wr(LBST_OFS_TIMING_B, LBST_B_RESET);
        cyc(1);
        @(posedge CLK_IN) #1 chk({LOCAL_CLOCK_OUT, LOCAL_RESET_OUT}, 2'b00);
        @(negedge CLK_IN) EE_LOADING_IN = 1'b1;
        cyc(4);
        chk(LOCAL_DATA_PINS_OE_OUT, 1'b0);
        EE_LOADING_IN = 1'b0;
        {RST_N_IN, PAR_PORT_IN} = 2'b01;
        cyc(3);
        chk(LOCAL_RESET_OUT, 1'b1);
        RST_N_IN = 1'b1;
        cyc(2);
        reg_rd(LBST_OFS_TIMING_A, LBST_A_RESET_PAR);
        reg_rd(LBST_OFS_TIMING_B, LBST_B_RESET_PAR);
        finish_test;
    end
endmodule
